// *** csi_top.sv ***
// Completer request delivery and completion intake of the stream interface.
// How it works
// - Abort last request beat on buffer ECC error.
// - No abort without payload; only on last.
// - Endpoint reports request payload error upstream.
// - Hint-present bit valid in first beat.
// - Hint type given in first beat.
// - Steering tag given in first beat.
// - One odd parity bit per request byte.
// - Unused upper parity bits held zero.
// - Unused upper keep bits are ignored.
// - Beat moves only when valid and ready.
// - Start-of-packet only in the first beat.
// - Client abort nullifies packet, sticky till end.
// - Parity mismatch nullifies, flags internal error.
//
// Added by the designer: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
module csi_top (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [255:0] req_src_data,
  input wire logic req_src_valid,
  input wire logic req_src_last,
  input wire logic req_src_has_payload,
  input wire logic req_src_ecc_err,
  input wire logic req_src_hint_present,
  input wire logic [1:0] req_src_hint_type,
  input wire logic [7:0] req_src_hint_tag,
  output logic req_src_ready,
  output logic [255:0] request_out_data,
  output logic request_out_valid,
  output logic request_out_last,
  output logic request_out_sop,
  output logic request_out_abort,
  output logic hint_present,
  output logic [1:0] hint_type,
  output logic [7:0] hint_steering_field,
  output logic [31:0] request_out_parity,
  input wire logic request_out_ready,
  input wire logic [255:0] completion_in_data,
  input wire logic [32:0] completion_in_sideband,
  input wire logic completion_in_last,
  input wire logic [7:0] completion_in_dword_keep,
  input wire logic completion_in_valid,
  output logic completion_in_ready,
  output logic [255:0] link_tx_data,
  output logic [7:0] link_tx_keep,
  output logic link_tx_last,
  output logic link_tx_valid,
  output logic link_tx_nullify,
  input wire logic link_tx_ready,
  output logic aer_payload_err,
  output logic aer_cpl_abort,
  output logic internal_uncorr_err
);

  // ==========================================================================
  // Declarations
  logic [3:0] ctrl, next_ctrl;
  logic [2:0] sticky, next_sticky;
  logic [31:0] next_wb_dat;
  logic next_wb_ack;
  logic par_en, ep_mode;
  logic [1:0] width_sel;
  logic [31:0] width_bmask;
  logic [7:0] width_kmask;
  csi_pkg::csi_pkt_e rq_state, next_rq_state;
  csi_pkg::csi_pkt_e cc_state, next_cc_state;
  logic rq_err, next_rq_err;
  logic rq_take, rq_drain, rq_beat_err, rq_abort_now;
  logic next_req_src_ready, next_rq_valid;
  logic [255:0] next_rq_data;
  logic next_rq_last, next_rq_sop, next_rq_abort;
  logic next_hint_present;
  logic [1:0] next_hint_type;
  logic [7:0] next_hint_tag;
  logic [31:0] next_rq_parity;
  logic next_aer_payload;
  logic cc_abort_seen, next_cc_abort_seen;
  logic cc_par_seen, next_cc_par_seen;
  logic cc_take, cc_drain, cc_abort_in, cc_mismatch;
  logic [31:0] cc_keep_bytes;
  logic next_cc_ready, next_tx_valid, next_tx_last, next_tx_nullify;
  logic [255:0] next_tx_data;
  logic [7:0] next_tx_keep;
  logic next_aer_cpl, next_int_err;
  csi_par_if rq_par ();
  csi_par_if cc_par ();

  // ==========================================================================
  // Parity calculators
  csi_parity #(.NBYTES(csi_pkg::BYTES)) u_rq_parity (.bus(rq_par.calc));
  csi_parity #(.NBYTES(csi_pkg::BYTES)) u_cc_parity (.bus(cc_par.calc));

  // ==========================================================================
  // Configuration decode
  // The width field selects which lanes carry meaning; an unknown code
  // falls back to the full bus rather than silencing every lane.
  always_comb begin
    par_en = ctrl[csi_pkg::CTRL_PAR_EN_BIT];
    ep_mode = ctrl[csi_pkg::CTRL_EP_BIT];
    width_sel = ctrl[csi_pkg::CTRL_WIDTH_LSB +: 2];
    if (width_sel == csi_pkg::WIDTH_64) begin
      width_bmask = csi_pkg::BMASK_64;
      width_kmask = csi_pkg::KMASK_64;
    end else if (width_sel == csi_pkg::WIDTH_128) begin
      width_bmask = csi_pkg::BMASK_128;
      width_kmask = csi_pkg::KMASK_128;
    end else begin
      width_bmask = csi_pkg::BMASK_256;
      width_kmask = csi_pkg::KMASK_256;
    end
  end

  // ==========================================================================
  // Wishbone slave
  // One wait state: ack rises the cycle after the strobe and falls the
  // cycle after that. Unmapped addresses read zero and ignore writes.
  // A write lands on the edge where the master sees ack, never earlier.
  always_comb begin
    next_ctrl = ctrl;
    next_sticky = sticky;
    next_wb_dat = wb_dat_o;
    next_wb_ack = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0]) begin
      if (wb_adr_i == csi_pkg::ADDR_CTRL) begin
        next_ctrl = wb_dat_i[3:0];
      end else if (wb_adr_i == csi_pkg::ADDR_STATUS) begin
        next_sticky = sticky & ~wb_dat_i[2:0];
      end
    end
    if (next_wb_ack && !wb_we_i) begin
      if (wb_adr_i == csi_pkg::ADDR_CTRL) begin
        next_wb_dat = {28'h0000000, ctrl};
      end else if (wb_adr_i == csi_pkg::ADDR_STATUS) begin
        next_wb_dat = {27'h0000000, (cc_state == csi_pkg::PKT_BODY),
                       (rq_state == csi_pkg::PKT_BODY), sticky};
      end else begin
        next_wb_dat = 32'h00000000;
      end
    end
    // A new event wins over a clear in the same cycle.
    if (rq_take && rq_abort_now) begin
      next_sticky[csi_pkg::ST_REQ_ABORT] = 1'b1;
    end
    if (cc_take && cc_abort_in) begin
      next_sticky[csi_pkg::ST_CPL_ABORT] = 1'b1;
    end
    if (cc_take && cc_mismatch) begin
      next_sticky[csi_pkg::ST_CPL_PARITY] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl <= csi_pkg::CTRL_RESET;
      sticky <= 3'h0;
      wb_dat_o <= 32'h00000000;
      wb_ack_o <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      sticky <= next_sticky;
      wb_dat_o <= next_wb_dat;
      wb_ack_o <= next_wb_ack;
    end
  end

  // ==========================================================================
  // Request delivery stage
  // Ready is registered, so the stage only accepts while empty; this costs
  // half rate but never overruns the single output register.
  assign rq_par.data = req_src_data;
  assign rq_par.byte_mask = width_bmask;

  always_comb begin
    rq_take = req_src_ready & req_src_valid;
    rq_drain = request_out_valid & request_out_ready;
    rq_beat_err = rq_err | req_src_ecc_err;
    rq_abort_now = req_src_last & req_src_has_payload & rq_beat_err;
    next_rq_state = rq_state;
    next_rq_err = rq_err;
    next_rq_valid = request_out_valid;
    next_rq_data = request_out_data;
    next_rq_last = request_out_last;
    next_rq_sop = request_out_sop;
    next_rq_abort = request_out_abort;
    next_hint_present = hint_present;
    next_hint_type = hint_type;
    next_hint_tag = hint_steering_field;
    next_rq_parity = request_out_parity;
    next_aer_payload = 1'b0;
    if (rq_drain) begin
      next_rq_valid = 1'b0;
      next_rq_abort = 1'b0; // Abort never stands outside a beat.
    end
    if (rq_take) begin
      next_rq_valid = 1'b1;
      next_rq_data = req_src_data;
      next_rq_last = req_src_last;
      next_rq_sop = (rq_state == csi_pkg::PKT_IDLE);
      next_rq_abort = rq_abort_now;
      next_rq_parity = rq_par.parity;
      // Hint fields carry content only in the first beat.
      if (rq_state == csi_pkg::PKT_IDLE) begin
        next_hint_present = req_src_hint_present;
        next_hint_type = req_src_hint_type;
        next_hint_tag = req_src_hint_tag;
      end else begin
        next_hint_present = 1'b0;
        next_hint_type = 2'h0;
        next_hint_tag = 8'h00;
      end
      next_aer_payload = rq_abort_now & ep_mode;
      if (req_src_last) begin
        next_rq_state = csi_pkg::PKT_IDLE;
        next_rq_err = 1'b0;
      end else begin
        next_rq_state = csi_pkg::PKT_BODY;
        next_rq_err = rq_beat_err;
      end
    end
    next_req_src_ready = ~next_rq_valid;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rq_state <= csi_pkg::PKT_IDLE;
      rq_err <= 1'b0;
      req_src_ready <= 1'b0;
      request_out_valid <= 1'b0;
      request_out_data <= 256'h0;
      request_out_last <= 1'b0;
      request_out_sop <= 1'b0;
      request_out_abort <= 1'b0;
      hint_present <= 1'b0;
      hint_type <= 2'h0;
      hint_steering_field <= 8'h00;
      request_out_parity <= 32'h00000000;
      aer_payload_err <= 1'b0;
    end else begin
      rq_state <= next_rq_state;
      rq_err <= next_rq_err;
      req_src_ready <= next_req_src_ready;
      request_out_valid <= next_rq_valid;
      request_out_data <= next_rq_data;
      request_out_last <= next_rq_last;
      request_out_sop <= next_rq_sop;
      request_out_abort <= next_rq_abort;
      hint_present <= next_hint_present;
      hint_type <= next_hint_type;
      hint_steering_field <= next_hint_tag;
      request_out_parity <= next_rq_parity;
      aer_payload_err <= next_aer_payload;
    end
  end

  // ==========================================================================
  // Completion intake stage
  // Parity is checked only on bytes of kept Dwords inside the configured
  // width, since the rest of the bus may carry anything.
  always_comb begin
    cc_keep_bytes = 32'h00000000;
    for (int i = 0; i < csi_pkg::BYTES; i++) begin
      cc_keep_bytes[i] = completion_in_dword_keep[i / 4];
    end
  end

  assign cc_par.data = completion_in_data;
  assign cc_par.byte_mask = width_bmask & cc_keep_bytes;

  always_comb begin
    cc_take = completion_in_ready & completion_in_valid;
    cc_drain = link_tx_valid & link_tx_ready;
    cc_abort_in = completion_in_sideband[csi_pkg::CC_ABORT_BIT];
    cc_mismatch = par_en & (|((cc_par.parity ^
                  completion_in_sideband[32:csi_pkg::CC_PARITY_LSB]) &
                  cc_par.byte_mask));
    next_cc_state = cc_state;
    next_cc_abort_seen = cc_abort_seen;
    next_cc_par_seen = cc_par_seen;
    next_tx_valid = link_tx_valid;
    next_tx_data = link_tx_data;
    next_tx_keep = link_tx_keep;
    next_tx_last = link_tx_last;
    next_tx_nullify = link_tx_nullify;
    next_aer_cpl = 1'b0;
    next_int_err = 1'b0;
    if (cc_drain) begin
      next_tx_valid = 1'b0;
    end
    if (cc_take) begin
      next_tx_valid = 1'b1;
      next_tx_data = completion_in_data;
      next_tx_keep = completion_in_dword_keep & width_kmask;
      next_tx_last = completion_in_last;
      // Either error taints the packet up to and including its last beat.
      next_tx_nullify = completion_in_last & (cc_abort_seen | cc_abort_in |
                        cc_par_seen | cc_mismatch);
      next_aer_cpl = cc_abort_in & ~cc_abort_seen & ep_mode;
      next_int_err = cc_mismatch & ~cc_par_seen;
      if (completion_in_last) begin
        next_cc_state = csi_pkg::PKT_IDLE;
        next_cc_abort_seen = 1'b0;
        next_cc_par_seen = 1'b0;
      end else begin
        next_cc_state = csi_pkg::PKT_BODY;
        next_cc_abort_seen = cc_abort_seen | cc_abort_in;
        next_cc_par_seen = cc_par_seen | cc_mismatch;
      end
    end
    next_cc_ready = ~next_tx_valid;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cc_state <= csi_pkg::PKT_IDLE;
      cc_abort_seen <= 1'b0;
      cc_par_seen <= 1'b0;
      completion_in_ready <= 1'b0;
      link_tx_valid <= 1'b0;
      link_tx_data <= 256'h0;
      link_tx_keep <= 8'h00;
      link_tx_last <= 1'b0;
      link_tx_nullify <= 1'b0;
      aer_cpl_abort <= 1'b0;
      internal_uncorr_err <= 1'b0;
    end else begin
      cc_state <= next_cc_state;
      cc_abort_seen <= next_cc_abort_seen;
      cc_par_seen <= next_cc_par_seen;
      completion_in_ready <= next_cc_ready;
      link_tx_valid <= next_tx_valid;
      link_tx_data <= next_tx_data;
      link_tx_keep <= next_tx_keep;
      link_tx_last <= next_tx_last;
      link_tx_nullify <= next_tx_nullify;
      aer_cpl_abort <= next_aer_cpl;
      internal_uncorr_err <= next_int_err;
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  AST_ABORT_ON_LAST: assert property (
    request_out_abort |-> request_out_last && request_out_valid)
    else $error("Request abort outside a last beat.");
  AST_ABORT_NO_PAYLOAD: assert property (
    rq_take && !req_src_has_payload |=> !request_out_abort)
    else $error("Request abort on a packet without payload.");
  AST_ABORT_CAUSE: assert property (
    rq_take && req_src_ecc_err && !req_src_last ##1
    first_match(##[0:8] rq_take) ##0 (req_src_last && req_src_has_payload)
    |=> request_out_abort)
    else $error("Earlier buffer error did not abort the packet.");
  AST_AER_REQ: assert property (
    rq_take && rq_abort_now && ep_mode |=> aer_payload_err && request_out_abort)
    else $error("Request payload error not reported.");
  AST_SOP_BODY: assert property (
    rq_take && rq_state == csi_pkg::PKT_BODY |=> !request_out_sop)
    else $error("Start of packet flagged inside a packet.");
  AST_HINT_FIRST: assert property (
    rq_take && rq_state == csi_pkg::PKT_IDLE
    |=> hint_type == $past(req_src_hint_type) && request_out_sop)
    else $error("Hint type not loaded in the first beat.");
  AST_TAG_QUIET: assert property (
    request_out_valid && !request_out_sop
    |-> !hint_present && hint_steering_field == 8'h00)
    else $error("Hint fields not quiet after the first beat.");
  AST_PARITY_ODD: assert property (
    rq_take |=> ^{request_out_data[7:0], request_out_parity[0]})
    else $error("Request parity of byte zero is not odd.");
  AST_PARITY_WIDTH: assert property (
    rq_take && width_sel == csi_pkg::WIDTH_64
    |=> request_out_parity[31:8] == 24'h000000)
    else $error("Upper parity bits not zero at 64-bit width.");
  AST_KEEP_MASK: assert property (
    cc_take && width_sel == csi_pkg::WIDTH_128 |=> link_tx_keep[7:4] == 4'h0)
    else $error("Unused keep bits passed to the link.");
  AST_LINK_HOLD: assert property (
    link_tx_valid && !link_tx_ready
    |=> link_tx_valid && $stable(link_tx_data) && !completion_in_ready)
    else $error("Completion beat lost while the link stalls.");
  AST_NULLIFY: assert property (
    cc_take && cc_abort_in && !completion_in_last ##1
    first_match(##[0:8] cc_take) ##0 completion_in_last |=> link_tx_nullify)
    else $error("Client abort did not nullify the packet.");
  AST_PAR_ERR: assert property (
    cc_take && cc_mismatch && !cc_par_seen |=> internal_uncorr_err)
    else $error("Completion parity error not reported.");
  AST_WB_ACK: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("Bus acknowledge not a single cycle.");

endmodule : csi_top

// *** csi_pkg.sv ***
// Shared constants and types of the completer stream interface.
package csi_pkg;

  // ==========================================================================
  // Stream widths
  localparam int DATA_W = 256;
  localparam int BYTES = 32;
  localparam int KEEP_W = 8;
  localparam int CC_USER_W = 33;
  localparam int WB_ADR_W = 4;

  // ==========================================================================
  // Completion sideband layout
  localparam int CC_ABORT_BIT = 0;
  localparam int CC_PARITY_LSB = 1;

  // ==========================================================================
  // Register map and fields
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam int CTRL_PAR_EN_BIT = 0;
  localparam int CTRL_EP_BIT = 1;
  localparam int CTRL_WIDTH_LSB = 2;
  localparam logic [3:0] CTRL_RESET = 4'hA;
  localparam int ST_REQ_ABORT = 0;
  localparam int ST_CPL_ABORT = 1;
  localparam int ST_CPL_PARITY = 2;
  localparam int ST_REQ_BUSY = 3;
  localparam int ST_CPL_BUSY = 4;
  localparam int ST_STICKY_W = 3;

  // ==========================================================================
  // Interface width selection and lane masks
  localparam logic [1:0] WIDTH_64 = 2'h0;
  localparam logic [1:0] WIDTH_128 = 2'h1;
  localparam logic [1:0] WIDTH_256 = 2'h2;
  localparam logic [31:0] BMASK_64 = 32'h000000FF;
  localparam logic [31:0] BMASK_128 = 32'h0000FFFF;
  localparam logic [31:0] BMASK_256 = 32'hFFFFFFFF;
  localparam logic [7:0] KMASK_64 = 8'h03;
  localparam logic [7:0] KMASK_128 = 8'h0F;
  localparam logic [7:0] KMASK_256 = 8'hFF;

  // ==========================================================================
  // Packet position of a stream
  typedef enum logic {PKT_IDLE, PKT_BODY} csi_pkt_e;

endpackage : csi_pkg

// *** csi_par_if.sv ***
// Carrier between the top level and a byte parity calculator.
`timescale 1ns/1ps
interface csi_par_if;
  logic [255:0] data;
  logic [31:0] byte_mask;
  logic [31:0] parity;
  modport src (output data, output byte_mask, input parity);
  modport calc (input data, input byte_mask, output parity);
endinterface : csi_par_if

// *** csi_parity.sv ***
// Per-byte odd parity calculator with a lane mask.
`timescale 1ns/1ps
module csi_parity #(
  parameter int NBYTES = 32
) (
  csi_par_if.calc bus
);

  // ==========================================================================
  // Parity lanes
  // Each bit makes its byte plus itself hold an odd count of ones; masked
  // lanes read zero so unused upper lanes stay quiet.
  genvar i;
  generate
    for (i = 0; i < NBYTES; i++) begin : g_lane
      assign bus.parity[i] = (~^bus.data[8*i +: 8]) & bus.byte_mask[i];
    end
  endgenerate

endmodule : csi_parity

// *** csi_client_model.sv ***
// Client model: consumes delivered requests and issues completion beats.
`timescale 1ns/1ps
module csi_client_model (
  input wire logic ref_clk,
  input wire logic stall,
  input wire logic [255:0] request_out_data,
  input wire logic request_out_valid,
  input wire logic request_out_last,
  input wire logic request_out_sop,
  input wire logic request_out_abort,
  input wire logic hint_present,
  input wire logic [1:0] hint_type,
  input wire logic [7:0] hint_steering_field,
  input wire logic [31:0] request_out_parity,
  output logic request_out_ready,
  output logic [255:0] completion_in_data,
  output logic [32:0] completion_in_sideband,
  output logic completion_in_last,
  output logic [7:0] completion_in_dword_keep,
  output logic completion_in_valid,
  input wire logic completion_in_ready
);
  logic [109:0] pend[$];
  logic [109:0] rq[$];
  logic [1:0] ph;
  int drops;
  // ==========================================================================
  // Request intake
  // Ready drops half the time when asked, so the stage must hold its beat.
  initial begin
    ph = 2'h0;
    drops = 0;
    request_out_ready = 1'b0;
    completion_in_valid = 1'b0;
    completion_in_data = '0;
    completion_in_sideband = '0;
    completion_in_last = 1'b0;
    completion_in_dword_keep = 8'h00;
  end
  // Beats are kept aside until the last one says whether to keep them.
  always @(posedge ref_clk) begin
    ph <= ph + 2'h1;
    request_out_ready <= !(stall && ph[1]);
    if (request_out_valid === 1'b1 && request_out_ready === 1'b1) begin
      pend.push_back({request_out_sop, request_out_last, request_out_abort,
        request_out_sop ? {hint_present, hint_type, hint_steering_field}
        : 11'h000, request_out_parity, request_out_data[63:0]});
      if (request_out_last === 1'b1) begin
        if (request_out_abort === 1'b1) begin
          drops++;
        end else begin
          while (pend.size() > 0) rq.push_back(pend.pop_front());
        end
        pend.delete();
      end
    end
  end
  // ==========================================================================
  // Completion issue
  // Valid stays up across a packet; a stalled beat is held whole.
  task automatic send_cpl(input logic [255:0] d, input logic [32:0] u,
    input logic l, input logic [7:0] k);
    completion_in_data <= d;
    completion_in_sideband <= u;
    completion_in_last <= l;
    completion_in_dword_keep <= k;
    completion_in_valid <= 1'b1;
    do @(posedge ref_clk); while (completion_in_ready !== 1'b1);
    if (l) begin
      completion_in_valid <= 1'b0;
      completion_in_data <= ~d;
      @(posedge ref_clk);
    end
  endtask : send_cpl
endmodule : csi_client_model

// *** tb_csi_top.sv ***
// Self-checking testbench of the completer stream interface.
`timescale 1ns/1ps
module tb_csi_top;
  localparam logic [255:0] D0 = {8{32'h1234ABCD}};
  localparam logic [255:0] D1 = {4{64'hF0E1D2C30055AA96}};
  logic ref_clk = 1'b0, rst = 1'b1, stall = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = '0, wb_dat_o, request_out_parity, rd;
  logic [255:0] req_src_data = '0, request_out_data, completion_in_data;
  logic req_src_valid = 1'b0, req_src_last = 1'b0, req_src_ecc_err = 1'b0;
  logic req_src_has_payload = 1'b0, req_src_hint_present = 1'b0;
  logic [1:0] req_src_hint_type = 2'h0, hint_type;
  logic [7:0] req_src_hint_tag = 8'h00, hint_steering_field;
  logic req_src_ready, request_out_valid, request_out_last, request_out_sop;
  logic request_out_abort, hint_present, request_out_ready;
  logic [32:0] completion_in_sideband;
  logic [7:0] completion_in_dword_keep, link_tx_keep;
  logic completion_in_last, completion_in_valid, completion_in_ready;
  logic [255:0] link_tx_data;
  logic link_tx_last, link_tx_valid, link_tx_nullify, link_tx_ready = 1'b0;
  logic aer_payload_err, aer_cpl_abort, internal_uncorr_err;
  logic [41:0] lq[$], eq[$];
  int bad_count = 0, cmp_count = 0, cyc_n = 0, aer_n = 0, cab_n = 0, ie_n = 0;

  csi_top dut_u (.*);
  csi_client_model cm (.*);

  // ==========================================================================
  // Clock, link side and event counters
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  // The link stalls every other cycle when asked, and its beats are logged.
  always @(posedge ref_clk) begin
    cyc_n++;
    link_tx_ready <= !stall || cyc_n[0];
    if (link_tx_valid === 1'b1 && link_tx_ready === 1'b1)
      lq.push_back({link_tx_nullify, link_tx_last, link_tx_keep,
        link_tx_data[31:0]});
    if (aer_payload_err === 1'b1) aer_n++;
    if (aer_cpl_abort === 1'b1) cab_n++;
    if (internal_uncorr_err === 1'b1) ie_n++;
  end
  // ==========================================================================
  // Helpers
  function automatic logic [31:0] par(input logic [255:0] d,
    input logic [31:0] m);
    for (int i = 0; i < 32; i++) par[i] = m[i] & ~^d[8*i+:8];
  endfunction : par

  task automatic chk(input string n, input logic [255:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %0h seen %0h", n, exp, got);
    end
  endtask : chk

  // Classic single-cycle Wishbone access; waits for the slave's ack.
  task automatic wb(input logic we, input logic [3:0] a,
    input logic [31:0] wd);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= wd;
    do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge ref_clk);
  endtask : wb

  task automatic rq_beat(input logic [255:0] d, input logic l, p, e, hp,
    input logic [1:0] ht, input logic [7:0] tg);
    req_src_data <= d;
    req_src_last <= l;
    req_src_has_payload <= p;
    req_src_ecc_err <= e;
    req_src_hint_present <= hp;
    req_src_hint_type <= ht;
    req_src_hint_tag <= tg;
    req_src_valid <= 1'b1;
    do @(posedge ref_clk); while (req_src_ready !== 1'b1);
    req_src_valid <= 1'b0;
    req_src_data <= ~d;
    @(posedge ref_clk);
  endtask : rq_beat

  // Sends one completion beat and books the beat the link should see.
  task automatic cpl(input logic [255:0] d, input logic ab, bad, l,
    input logic [7:0] k, input logic [9:0] ex);
    eq.push_back({ex, d[31:0]});
    cm.send_cpl(d, {par(d, 32'hFFFFFFFF) ^ {31'h0, bad}, ab}, l, k);
  endtask : cpl

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  // ==========================================================================
  // Watchdog: the tests need well under a thousand cycles.
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    print_verdict();
  end
  // ==========================================================================
  // Main sequence
  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    wb(1'b0, csi_pkg::ADDR_CTRL, '0);
    chk("ctrl_reset", rd, csi_pkg::CTRL_RESET);
    wb(1'b0, 4'h8, '0);
    chk("unmapped", rd, '0);
    // Hinted two-beat request, then an aborted one, then one without payload.
    rq_beat(D0, 1'b0, 1'b1, 1'b0, 1'b1, 2'h2, 8'h5A);
    rq_beat(D1, 1'b1, 1'b1, 1'b0, 1'b0, 2'h0, 8'h00);
    stall <= 1'b1;
    rq_beat(D0, 1'b0, 1'b1, 1'b1, 1'b0, 2'h0, 8'h00);
    rq_beat(D1, 1'b1, 1'b1, 1'b0, 1'b0, 2'h0, 8'h00);
    rq_beat(D1, 1'b1, 1'b0, 1'b1, 1'b0, 2'h0, 8'h00);
    repeat (10) @(posedge ref_clk);
    chk("req0", cm.rq[0], {4'h9, 2'h2, 8'h5A, par(D0, csi_pkg::BMASK_256),
      D0[63:0]});
    chk("req1", cm.rq[1], {14'h1000, par(D1, csi_pkg::BMASK_256),
      D1[63:0]});
    chk("drops", cm.drops, 1);
    chk("aer", aer_n, 1);
    chk("nopay", cm.rq[2][109:107], 3'h6);
    // Narrow 64-bit mode with parity checking on.
    wb(1'b1, csi_pkg::ADDR_CTRL, 32'h3);
    rq_beat(D0, 1'b1, 1'b1, 1'b0, 1'b0, 2'h0, 8'h00);
    repeat (10) @(posedge ref_clk);
    chk("par64", cm.rq[3][95:64], par(D0, csi_pkg::BMASK_64));
    cpl(D0, 1'b0, 1'b0, 1'b1, 8'hFF, {2'h1, csi_pkg::KMASK_64});
    cpl(D1, 1'b0, 1'b1, 1'b0, 8'hFF, {2'h0, csi_pkg::KMASK_64});
    cpl(D0, 1'b0, 1'b0, 1'b1, 8'h01, {2'h3, 8'h01});
    // 128-bit width: abort in mid-packet, then a clean packet.
    wb(1'b1, csi_pkg::ADDR_CTRL, 32'h7);
    cpl(D0, 1'b0, 1'b0, 1'b0, 8'hFF, {2'h0, csi_pkg::KMASK_128});
    cpl(D1, 1'b1, 1'b0, 1'b0, 8'hFF, {2'h0, csi_pkg::KMASK_128});
    cpl(D0, 1'b0, 1'b0, 1'b1, 8'h0F, {2'h3, 8'h0F});
    cpl(D1, 1'b0, 1'b0, 1'b1, 8'hFF, {2'h1, csi_pkg::KMASK_128});
    repeat (12) @(posedge ref_clk);
    chk("link_n", lq.size(), eq.size());
    foreach (eq[i]) chk("link", lq[i], eq[i]);
    chk("ierr", ie_n, 1);
    chk("cab", cab_n, 1);
    wb(1'b0, csi_pkg::ADDR_STATUS, '0);
    chk("status", rd[2:0], 3'h7);
    wb(1'b1, csi_pkg::ADDR_STATUS, 32'h7);
    wb(1'b0, csi_pkg::ADDR_STATUS, '0);
    chk("status_clr", rd[2:0], 3'h0);
    print_verdict();
  end
endmodule : tb_csi_top
